// ==== bench/bscu_checker.sv ====
/* Port timing checks of the cipher unit.
   Assumes a bind into bscu_top and one clock. */
`timescale 1ns/100ps
`default_nettype none
// ***********
// Checker
// ***********
module bscu_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic key_load,
    input wire logic [4:0] key_bytes,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic key_ready,
    input wire logic key_error,
    input wire logic out_valid,
    input wire logic [31:0] out_data,
    input wire logic out_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Key length inside 5..16 bytes
    wire logic len_ok = key_bytes >= 5'h05 && key_bytes <= 5'h10;
    // Words taken in the last four cycles; a load during those crypt cycles is ignored
    logic [3:0] take_hist;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            take_hist <= 4'h0;
        end else begin
            take_hist <= {take_hist[2:0], in_valid && in_ready && !key_load};
        end
    end
    // Only loads seen while ready and not crypting are judged
    wire logic load_seen = key_load && key_ready && (take_hist == 4'h0);
    property p_key_done; load_seen && len_ok |-> ##[512:513] key_ready; endproperty
    a_key_done: assert property (p_key_done) else $error("key table late");
    property p_key_drop; load_seen && len_ok |=> !key_ready && !in_ready; endproperty
    a_key_drop: assert property (p_key_drop) else $error("key not dropped");
    property p_key_gate; !key_ready |-> !in_ready; endproperty
    a_key_gate: assert property (p_key_gate) else $error("word taken unkeyed");
    property p_bad_len; load_seen && !len_ok |=> key_error && key_ready; endproperty
    a_bad_len: assert property (p_bad_len) else $error("bad length kept");
    property p_good_len; load_seen && len_ok |=> !key_error; endproperty
    a_good_len: assert property (p_good_len) else $error("good length refused");
    property p_bytewise; in_valid && in_ready && !key_load |=> !in_ready [*4]; endproperty
    a_bytewise: assert property (p_bytewise) else $error("word not serial");
    property p_word_out; in_valid && in_ready && !key_load && !out_valid |-> ##[4:6] out_valid;
    endproperty
    a_word_out: assert property (p_word_out) else $error("word missing");
    property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    a_out_hold: assert property (p_out_hold) else $error("unread word lost");
    // Main scenarios reached
    c_bad: cover property (key_load && key_ready && !len_ok);
    c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
    c_word: cover property (in_valid && in_ready);
endmodule
bind bscu_top bscu_checker chk (.ref_clk, .reset_n, .key_load, .key_bytes, .in_valid,
    .in_ready, .key_ready, .key_error, .out_valid, .out_data, .out_ready);
`default_nettype wire

// ==== bench/bscu_host_model.sv ====
/* Host side that reads output words.
   Assumes the bench sets stall off the rising edge. */
`timescale 1ns/100ps
`default_nettype none
// ***********
// Host reader
// ***********
module bscu_host_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [31:0] out_data,
    output logic out_ready
);
    // Words read, in arrival order
    logic [31:0] got[$];
    // Ready moves on the falling edge so the unit samples it settled
    initial begin
        out_ready = 1'h0;
        forever @(negedge ref_clk) out_ready <= reset_n && !stall;
    end
    // A word is read at the edge where both are high
    always @(posedge ref_clk) if (reset_n && out_valid && out_ready) got.push_back(out_data);
endmodule
`default_nettype wire

// ==== bench/bscu_top_test.sv ====
/* Self-checking bench of the cipher unit.
   Assumes bscu_top, the checker and the host model. */
`timescale 1ns/100ps
`default_nettype none
// ***********
// Bench
// ***********
module bscu_top_test;
    logic ref_clk, reset_n, key_load, in_valid, stall;
    logic [127:0] key_data;
    logic [4:0] key_bytes;
    logic [31:0] in_data;
    wire logic in_ready, key_ready, key_error, out_valid, out_ready;
    wire logic [31:0] out_data;
    int errors = 0;
    int checked = 0;
    // Reference swap table and stream indices
    logic [7:0] s[256];
    int si, sj;
    logic [31:0] exp_q[$];
    logic [31:0] ct[$];
    bscu_top dut (.ref_clk, .reset_n, .key_load, .key_data, .key_bytes, .in_valid, .in_data,
        .in_ready, .key_ready, .key_error, .out_valid, .out_data, .out_ready);
    bscu_host_model host (.ref_clk, .reset_n, .stall, .out_valid, .out_data, .out_ready);
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = !ref_clk;
    end
    task automatic check(string what, logic [31:0] e, logic [31:0] v);
        checked++;
        if (e !== v) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, v);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Next keystream byte; the stream runs on across words
    function automatic logic [7:0] ks_next;
        logic [7:0] t;
        si = (si + 1) % 256;
        sj = (sj + s[si]) % 256;
        t = s[si];
        s[si] = s[sj];
        s[sj] = t;
        return s[(int'(s[si]) + s[sj]) % 256];
    endfunction
    // Key goes in before any word; bad lengths leave the reference alone
    task automatic load_key(logic [127:0] k, logic [4:0] n);
        int a, b;
        logic [7:0] t;
        @(negedge ref_clk);
        key_data = k;
        key_bytes = n;
        key_load = 1'h1;
        @(negedge ref_clk);
        key_load = 1'h0;
        if (n < 5 || n > 16) return;
        for (a = 0; a < 256; a++) s[a] = a[7:0];
        b = 0;
        for (a = 0; a < 256; a++) begin
            b = (b + s[a] + k[8*(a%n)+:8]) % 256;
            t = s[a];
            s[a] = s[b];
            s[b] = t;
        end
        si = 0;
        sj = 0;
        for (a = 0; a < 600 && key_ready !== 1'h1; a++) @(negedge ref_clk);
        if (key_ready !== 1'h1) begin
            check("key_ready in time", 1'h1, key_ready);
            complete_run;
        end
    endtask
    // Expected word: top byte first, each byte in its own place
    task automatic send(logic [31:0] w);
        int c;
        logic [31:0] e;
        for (c = 3; c >= 0; c--) e[8*c+:8] = w[8*c+:8] ^ ks_next();
        exp_q.push_back(e);
        @(negedge ref_clk);
        in_data = w;
        in_valid = 1'h1;
        for (c = 0; c < 100 && in_ready !== 1'h1; c++) @(negedge ref_clk);
        if (in_ready !== 1'h1) begin
            check("in_ready in time", 1'h1, in_ready);
            complete_run;
        end
        @(negedge ref_clk);
        in_valid = 1'h0;
    endtask
    task automatic drain(string what);
        int c;
        for (c = 0; c < 300 && host.got.size() < exp_q.size(); c++) @(negedge ref_clk);
        check("word count", exp_q.size(), host.got.size());
        while (exp_q.size() > 0 && host.got.size() > 0) check(what, exp_q.pop_front(), host.got.pop_front());
    endtask
    // Short key refused from idle, then a 40-bit key and back-to-back words
    task automatic t_short;
        load_key(128'h0102030405, 5'h04);
        check("key_error", 1'h1, key_error);
        check("key_ready", 1'h0, key_ready);
        load_key(128'h0102030405, 5'h05);
        check("key_error", 1'h0, key_error);
        send(32'h00000000);
        send(32'hdeadbeef);
        drain("short key word");
    endtask
    // 128-bit key, reader stalls until two words fill the buffer and in_ready drops; third word sent after release
    task automatic t_stall;
        load_key(128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0, 5'h10);
        stall = 1'h1;
        send(32'h11223344);
        send(32'h55667788);
        repeat (10) @(negedge ref_clk);
        check("in_ready full", 1'h0, in_ready);
        check("out_valid held", 1'h1, out_valid);
        stall = 1'h0;
        send(32'h99aabbcc);
        ct = exp_q;
        drain("stalled word");
    endtask
    // Same key again turns the ciphertext back to the plaintext
    task automatic t_decrypt;
        load_key(128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0, 5'h10);
        foreach (ct[i]) send(ct[i]);
        check("plain 0", 32'h11223344, exp_q[0]);
        check("plain 1", 32'h55667788, exp_q[1]);
        check("plain 2", 32'h99aabbcc, exp_q[2]);
        drain("decrypted word");
    endtask
    // Too long a key while ready: refused, old stream goes on
    task automatic t_long;
        load_key(128'h0, 5'h11);
        check("key_error", 1'h1, key_error);
        check("key_ready", 1'h1, key_ready);
        send(32'ha5a5a5a5);
        drain("kept key word");
    endtask
    initial begin
        reset_n = 1'h0;
        key_load = 1'h0;
        in_valid = 1'h0;
        stall = 1'h0;
        key_data = 128'h0;
        key_bytes = 5'h00;
        in_data = 32'h0;
        repeat (4) @(negedge ref_clk);
        reset_n = 1'h1;
        t_short;
        t_stall;
        t_decrypt;
        t_long;
        complete_run;
    end
endmodule
`default_nettype wire

// ==== core/bscu_params.svh ====
/*
 * Constants of the byte stream cipher unit: table size, key length limits,
 * word packing and output buffer depth.
 * Assumes it is included by bare name from files under core/.
 */
`ifndef BSCU_PARAMS_SVH
`define BSCU_PARAMS_SVH

// Permutation table holds one byte per entry
`define BSCU_TABLE_LAST 8'hff
// Shortest key in bytes (40 bits)
`define BSCU_KEY_MIN_BYTES 5'h05
// Longest key in bytes (128 bits)
`define BSCU_KEY_MAX_BYTES 5'h10
// Last byte position inside a 32-bit word
`define BSCU_LAST_BYTE 2'h3
// Entries in the output buffer
`define BSCU_BUF_DEPTH 2'h2
// Empty buffer count
`define BSCU_BUF_EMPTY 2'h0

`endif

// ==== core/bscu_pkg.sv ====
/*
 * Types of the byte stream cipher unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bscu_pkg;

    // Sequencer states, Gray coded along load, mix, ready, crypt
    typedef enum logic [2:0] {
        BSCU_IDLE  = 3'h0,
        BSCU_FILL  = 3'h1,
        BSCU_MIX   = 3'h3,
        BSCU_READY = 3'h2,
        BSCU_CRYPT = 3'h6
    } bscu_state_type;

endpackage

// ==== core/bscu_top.sv ====
/*
 * Byte stream cipher unit: loads a 40..128 bit key, permutes its internal
 * byte table, then transforms 32-bit words one byte per clock.
 * Assumes a host on the same clock that drives key_load and the input
 * and output valid/ready handshakes; no register bus.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bscu_params.svh"

module bscu_top (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic key_load,
    input wire logic [127:0] key_data,
    input wire logic [4:0] key_bytes,
    input wire logic in_valid,
    input wire logic [31:0] in_data,
    output logic in_ready,
    output logic key_ready,
    output logic key_error,
    output logic out_valid,
    output logic [31:0] out_data,
    input wire logic out_ready
);

    // ************************************************************
    // State
    // ************************************************************
    bscu_pkg::bscu_state_type state_r, state_nxt; // Sequencer
    logic [7:0] table_r [0:255]; // Permutation table in flops
    logic [7:0] table_nxt [0:255];
    logic [127:0] key_r, key_nxt; // Latched session key
    logic [4:0] klen_r, klen_nxt; // Key length in bytes
    logic [3:0] kidx_r, kidx_nxt; // Key byte index, wraps at length
    logic [7:0] idx_r, idx_nxt; // Table index i
    logic [7:0] jdx_r, jdx_nxt; // Table index j
    logic [1:0] step_r, step_nxt; // Byte step within a word
    logic [31:0] word_r, word_nxt; // Word being transformed
    logic key_ready_r, key_ready_nxt; // Permutation done
    logic key_error_r, key_error_nxt; // Last key load refused
    logic in_ready_r, in_ready_nxt;
    // Two-entry output buffer
    logic [31:0] buf_r [0:1];
    logic [31:0] buf_nxt [0:1];
    logic wptr_r, wptr_nxt; // Write slot
    logic rptr_r, rptr_nxt; // Read slot
    logic [1:0] count_r, count_nxt; // Words held
    logic out_valid_r, out_valid_nxt;
    logic [31:0] out_data_r, out_data_nxt;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Whole datapath in one process: table swap, key mix and byte crypt
    always_comb begin
        logic [7:0] ii; // Index used this cycle
        logic [7:0] jn; // New j
        logic [7:0] si; // Table[i] before swap
        logic [7:0] sj; // Table[j] before swap
        logic [7:0] ts; // Keystream table address
        logic [7:0] ks; // Keystream byte
        logic [7:0] kb; // Current key byte
        logic push; // Result word enters buffer
        logic pop; // Host takes head word
        ii = 8'h00;
        jn = 8'h00;
        si = 8'h00;
        sj = 8'h00;
        ts = 8'h00;
        ks = 8'h00;
        kb = 8'h00;
        push = 1'b0;
        pop = out_valid_r && out_ready;
        state_nxt = state_r;
        for (int n = 0; n < 256; n++) begin
            table_nxt[n] = table_r[n];
        end
        key_nxt = key_r;
        klen_nxt = klen_r;
        kidx_nxt = kidx_r;
        idx_nxt = idx_r;
        jdx_nxt = jdx_r;
        step_nxt = step_r;
        word_nxt = word_r;
        key_ready_nxt = key_ready_r;
        key_error_nxt = key_error_r;
        buf_nxt[0] = buf_r[0];
        buf_nxt[1] = buf_r[1];
        wptr_nxt = wptr_r;
        rptr_nxt = rptr_r;
        case (state_r)
            bscu_pkg::BSCU_IDLE, bscu_pkg::BSCU_READY: begin
                // Key loads only between words, so a word is never cut in half
                if (key_load) begin
                    if (key_bytes >= `BSCU_KEY_MIN_BYTES &&
                        key_bytes <= `BSCU_KEY_MAX_BYTES) begin
                        key_nxt = key_data;
                        klen_nxt = key_bytes;
                        key_error_nxt = 1'b0;
                        key_ready_nxt = 1'b0;
                        idx_nxt = 8'h00;
                        state_nxt = bscu_pkg::BSCU_FILL;
                    end else begin
                        // Out of range length: refused, old key kept
                        key_error_nxt = 1'b1;
                    end
                end else if (state_r == bscu_pkg::BSCU_READY && in_valid && in_ready_r) begin
                    // Word accepted only after the key permutation, on host
                    word_nxt = in_data;
                    step_nxt = 2'h0;
                    state_nxt = bscu_pkg::BSCU_CRYPT;
                end
            end
            bscu_pkg::BSCU_FILL: begin
                // Identity fill of the table, one entry a cycle
                table_nxt[idx_r] = idx_r;
                idx_nxt = idx_r + 8'h01;
                if (idx_r == `BSCU_TABLE_LAST) begin
                    jdx_nxt = 8'h00;
                    kidx_nxt = 4'h0;
                    state_nxt = bscu_pkg::BSCU_MIX;
                end
            end
            bscu_pkg::BSCU_MIX: begin
                // Key permutation: j += T[i] + key byte, then swap
                kb = key_r[{kidx_r, 3'h0} +: 8];
                si = table_r[idx_r];
                jn = jdx_r + si + kb;
                sj = table_r[jn];
                table_nxt[idx_r] = sj;
                table_nxt[jn] = si;
                jdx_nxt = jn;
                kidx_nxt = ({1'b0, kidx_r} == klen_r - 5'h01) ? 4'h0 : kidx_r + 4'h1;
                idx_nxt = idx_r + 8'h01;
                if (idx_r == `BSCU_TABLE_LAST) begin
                    // Stream indices restart from zero after the mix
                    idx_nxt = 8'h00;
                    jdx_nxt = 8'h00;
                    key_ready_nxt = 1'b1;
                    state_nxt = bscu_pkg::BSCU_READY;
                end
            end
            bscu_pkg::BSCU_CRYPT: begin
                // One byte per cycle; XOR with keystream, so decrypt is identical
                ii = idx_r + 8'h01;
                si = table_r[ii];
                jn = jdx_r + si;
                sj = table_r[jn];
                table_nxt[ii] = sj;
                table_nxt[jn] = si;
                ts = si + sj;
                // Read the table as it stands after the swap
                if (ts == ii) begin
                    ks = sj;
                end else if (ts == jn) begin
                    ks = si;
                end else begin
                    ks = table_r[ts];
                end
                idx_nxt = ii;
                jdx_nxt = jn;
                word_nxt[{`BSCU_LAST_BYTE - step_r, 3'h0} +: 8] =
                    word_r[{`BSCU_LAST_BYTE - step_r, 3'h0} +: 8] ^ ks;
                step_nxt = step_r + 2'h1;
                if (step_r == `BSCU_LAST_BYTE) begin
                    push = 1'b1;
                    state_nxt = bscu_pkg::BSCU_READY;
                end
            end
            default: begin
                state_nxt = bscu_pkg::BSCU_IDLE;
            end
        endcase
        // Buffer bookkeeping; a word is taken only with room, so push never overflows
        if (push) begin
            buf_nxt[wptr_r] = word_nxt;
            wptr_nxt = ~wptr_r;
        end
        if (pop) begin
            rptr_nxt = ~rptr_r;
        end
        count_nxt = count_r + {1'b0, push} - {1'b0, pop};
        out_valid_nxt = (count_nxt != `BSCU_BUF_EMPTY);
        out_data_nxt = buf_nxt[rptr_nxt];
        // Stall input while the buffer is full, back-pressure
        in_ready_nxt = (state_nxt == bscu_pkg::BSCU_READY) &&
                       (count_nxt < `BSCU_BUF_DEPTH) && !key_load;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Synchronous active-low reset; the table itself needs none
    always_ff @(posedge ref_clk) begin
        for (int n = 0; n < 256; n++) begin
            table_r[n] <= table_nxt[n];
        end
        key_r <= key_nxt;
        word_r <= word_nxt;
        if (!reset_n) begin
            state_r <= bscu_pkg::BSCU_IDLE;
            klen_r <= `BSCU_KEY_MIN_BYTES;
            kidx_r <= 4'h0;
            idx_r <= 8'h00;
            jdx_r <= 8'h00;
            step_r <= 2'h0;
            key_ready_r <= 1'b0;
            key_error_r <= 1'b0;
            in_ready_r <= 1'b0;
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            count_r <= `BSCU_BUF_EMPTY;
            // Buffer cleared so out_data reads zero until the first word
            buf_r[0] <= 32'h0000_0000;
            buf_r[1] <= 32'h0000_0000;
            out_valid_r <= 1'b0;
            out_data_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            klen_r <= klen_nxt;
            kidx_r <= kidx_nxt;
            idx_r <= idx_nxt;
            jdx_r <= jdx_nxt;
            step_r <= step_nxt;
            key_ready_r <= key_ready_nxt;
            key_error_r <= key_error_nxt;
            in_ready_r <= in_ready_nxt;
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            count_r <= count_nxt;
            buf_r[0] <= buf_nxt[0];
            buf_r[1] <= buf_nxt[1];
            out_valid_r <= out_valid_nxt;
            out_data_r <= out_data_nxt;
        end
    end

    // Outputs straight from flops
    assign in_ready = in_ready_r;
    assign key_ready = key_ready_r;
    assign key_error = key_error_r;
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

endmodule
`default_nettype wire
